/* File: rtl/dsc_pkg.sv */
// Constants for the serial DAC control block.
// Assumes a 125 MHz system clock; all pins arrive asynchronously.
package dsc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 16;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int CODE_MSB = 19;
  localparam int CODE_LSB = 4;
  localparam int CTL_SWRST = 19;
  localparam int CTL_PD_HI = 18;
  localparam int CTL_PD_LO = 17;
  localparam int CTL_REFDIS = 16;
  localparam int CTL_GAIN = 15;
  localparam int CTL_DAISY_CHAIN_ENABLE = 14;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE = 4'h2;
  localparam logic [3:0] CMD_WR_BOTH = 4'h3;
  localparam logic [3:0] CMD_WR_CTRL = 4'h4;
  localparam logic [3:0] CMD_READBACK = 4'h5;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ = 2'h3;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [11:0] APB_CFG = 12'h000;
  localparam logic [11:0] APB_CODES = 12'h004;
  localparam logic [11:0] APB_STATE = 12'h008;
  localparam int CFG_LOAD_EN = 0;
  localparam int CFG_FRAME_EN = 1;
  localparam logic [1:0] CFG_RESET = 2'h3;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_HWRST = 4;
  localparam int PIN_COUNT = 5;
  // Hardware reset assumed asserted until proven released
  localparam logic [4:0] PIN_RESET = 5'h0A;
  localparam int WAKE_REF_ON_NS = 4000;
  localparam int WAKE_REF_OFF_US = 600;
  localparam int WAKE_REF_ON_CYC = WAKE_REF_ON_NS * CLK_MHZ / 1000;
  localparam int WAKE_REF_OFF_CYC = WAKE_REF_OFF_US * CLK_MHZ;
  localparam int WAKE_CNT_BITS = 17;
  typedef enum logic [2:0] {
    DSC_ST_ACTIVE = 3'h1,
    DSC_ST_DOWN = 3'h2,
    DSC_ST_WAKE = 3'h4
  } dsc_out_state_t;
endpackage

/* File: rtl/dsc_pin_if.sv */
// Carrier between the pin synchroniser and the control core.
// Raw pins go in, filtered levels come back on the same clock.
`timescale 1ns/1ps
interface dsc_pin_if;
  logic [dsc_pkg::PIN_COUNT-1:0] raw;
  logic [dsc_pkg::PIN_COUNT-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

/* File: rtl/dsc_pin_sync.sv */
// Three-stage synchroniser with agreement filter, one lane per pin.
// Assumes pins change slower than a few system clocks.
`timescale 1ns/1ps
module dsc_pin_sync #(
  parameter int WIDTH = dsc_pkg::PIN_COUNT,
  parameter logic [dsc_pkg::PIN_COUNT-1:0] RESET_VAL = dsc_pkg::PIN_RESET
) (
  input wire logic clk,
  input wire logic rst_b,
  dsc_pin_if.sync pins
);
  // Refused at elaboration: the carrier has a fixed lane count
  if (WIDTH != dsc_pkg::PIN_COUNT)
  begin : g_width_check
    $error("dsc_pin_sync: width must match the pin carrier");
  end

  // Net, not variable: each lane drives its own bit
  wire logic [WIDTH-1:0] clean_bus;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_lane
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic clean_reg;
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1_reg <= RESET_VAL[i];
          s2_reg <= RESET_VAL[i];
          s3_reg <= RESET_VAL[i];
        end
        else
        begin
          s1_reg <= pins.raw[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // A change counts only once two late stages agree
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          clean_reg <= RESET_VAL[i];
        end
        else if (s2_reg == s3_reg)
        begin
          clean_reg <= s3_reg;
        end
      end
      assign clean_bus[i] = clean_reg;
    end
  endgenerate
  assign pins.clean = clean_bus;
endmodule

/* File: rtl/dsc_core.sv */
// Control logic of a single-channel serial voltage DAC with APB status.
// Assumes serial pins and reset pin are asynchronous to clk.
// Behaviour
// - 24-bit MSB-first frame, decoded at sync rise
// - Six command codes, nop through readback
// - Chain flag routes shifted data to data-out
// - Two select bits pick output load state
// - Any power-down turns the amplifier off
// - Bias and string stay on; reference optional
// - Weak data-out pull removed in power-down
// - DAC register kept and writable in power-down
// - Wake delay 4 us, or 600 us reference off
// - Control reset bit clears codes and fields
// - Software reset bit clears itself afterwards
// - Readback shifts input code out next frame
// - Data-out driven only during readback or chain
// - Readback clears chain flag; host rewrites it
// - Input register preloads, DAC register drives output
// - Load strobe fall copies input into DAC
// - Load strobe during shifting is ignored
// - Reset pin zeros codes, defaults fields
// - Output stays zero until new load
// - Commands ignored while reset pin low
// - Reference start waits for reset pin release
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module dsc_core #(
  parameter int WAKE_OFF_CYC = dsc_pkg::WAKE_REF_OFF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic sdi,
  input wire logic load_strobe_n,
  input wire logic hw_reset_n,
  output logic sdo_out,
  output logic sdo_oe,
  output logic sdo_pull_en,
  output logic [dsc_pkg::CODE_BITS-1:0] dac_code,
  output logic amp_enable,
  output logic load_1k_en,
  output logic load_100k_en,
  output logic out_hiz,
  output logic gain_double,
  output logic ref_enable,
  output logic bias_enable,
  output logic output_valid,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int WAKE_ON_BOUND = 520;
  localparam int WAKE_ON_CYC = dsc_pkg::WAKE_REF_ON_CYC;

  if (WAKE_OFF_CYC < 1 || WAKE_OFF_CYC >= (1 << dsc_pkg::WAKE_CNT_BITS))
  begin : g_wake_check
    $error("dsc_core: WAKE_OFF_CYC out of counter range");
  end

  dsc_pin_if pin_bus ();
  assign pin_bus.raw = {hw_reset_n, load_strobe_n, sdi, frame_sync_n, sclk};
  dsc_pin_sync #(
    .WIDTH(dsc_pkg::PIN_COUNT),
    .RESET_VAL(dsc_pkg::PIN_RESET)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pins(pin_bus.sync)
  );

  logic [4:0] prev_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_reg <= dsc_pkg::PIN_RESET;
    end
    else
    begin
      prev_reg <= pin_bus.clean;
    end
  end

  logic hw_act;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic load_fall;
  logic sdi_f;
  assign hw_act = !pin_bus.clean[dsc_pkg::PIN_HWRST];
  assign sclk_fall = prev_reg[dsc_pkg::PIN_SCLK] && !pin_bus.clean[dsc_pkg::PIN_SCLK];
  assign sync_fall = prev_reg[dsc_pkg::PIN_SYNC] && !pin_bus.clean[dsc_pkg::PIN_SYNC];
  assign sync_rise = !prev_reg[dsc_pkg::PIN_SYNC] && pin_bus.clean[dsc_pkg::PIN_SYNC];
  assign load_fall = prev_reg[dsc_pkg::PIN_LOAD] && !pin_bus.clean[dsc_pkg::PIN_LOAD];
  assign sdi_f = pin_bus.clean[dsc_pkg::PIN_SDI];

  logic [1:0] cfg_reg;
  logic in_frame_reg;
  logic [23:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic rb_pending_reg;
  logic rb_active_reg;
  logic [23:0] rb_shift_reg;
  logic [15:0] input_reg;
  logic [15:0] dac_reg;
  logic soft_rst_reg;
  logic [1:0] pd_reg;
  logic ref_dis_reg;
  logic gain_reg;
  logic daisy_chain_enable_reg;
  logic ref_init_reg;

  // Short frames are dropped; longer ones only count when chained
  logic frame_done;
  logic [3:0] cmd;
  logic [15:0] code_in;
  assign frame_done = sync_rise && in_frame_reg && !hw_act
    && (bit_cnt_reg == 5'(dsc_pkg::FRAME_BITS)
    || (daisy_chain_enable_reg && bit_cnt_reg > 5'(dsc_pkg::FRAME_BITS)));
  assign cmd = shift_reg[dsc_pkg::CMD_MSB:dsc_pkg::CMD_LSB];
  assign code_in = shift_reg[dsc_pkg::CODE_MSB:dsc_pkg::CODE_LSB];

  logic wr_ctrl;
  logic do_soft_rst;
  assign wr_ctrl = frame_done && cmd == dsc_pkg::CMD_WR_CTRL;
  assign do_soft_rst = wr_ctrl && shift_reg[dsc_pkg::CTL_SWRST];
  logic hw_load;
  assign hw_load = load_fall && !in_frame_reg && !sync_rise
    && cfg_reg[dsc_pkg::CFG_LOAD_EN];

  // Frame capture; the reset pin aborts any frame in flight
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_frame_reg <= 1'b0;
      shift_reg <= 24'h000000;
      bit_cnt_reg <= 5'h00;
    end
    else if (hw_act)
    begin
      in_frame_reg <= 1'b0;
    end
    else if (sync_fall && cfg_reg[dsc_pkg::CFG_FRAME_EN])
    begin
      in_frame_reg <= 1'b1;
      bit_cnt_reg <= 5'h00;
    end
    else if (sync_rise)
    begin
      in_frame_reg <= 1'b0;
    end
    else if (sclk_fall && in_frame_reg)
    begin
      shift_reg <= {shift_reg[22:0], sdi_f};
      if (bit_cnt_reg != 5'h1F)
      begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Code registers: input preloads, DAC register drives the output
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_reg <= dsc_pkg::CODE_RESET;
      dac_reg <= dsc_pkg::CODE_RESET;
    end
    else if (hw_act || do_soft_rst)
    begin
      input_reg <= dsc_pkg::CODE_RESET;
      dac_reg <= dsc_pkg::CODE_RESET;
    end
    else if (frame_done && cmd == dsc_pkg::CMD_WR_INPUT)
    begin
      input_reg <= code_in;
    end
    else if (frame_done && cmd == dsc_pkg::CMD_WR_BOTH)
    begin
      input_reg <= code_in;
      dac_reg <= code_in;
    end
    else if ((frame_done && cmd == dsc_pkg::CMD_UPDATE) || hw_load)
    begin
      dac_reg <= input_reg;
    end
  end

  // Control fields; reset bit lives one cycle then clears
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soft_rst_reg <= 1'b0;
      pd_reg <= dsc_pkg::PD_NORMAL;
      ref_dis_reg <= 1'b0;
      gain_reg <= 1'b0;
      daisy_chain_enable_reg <= 1'b0;
    end
    else if (hw_act || do_soft_rst)
    begin
      soft_rst_reg <= do_soft_rst && !hw_act;
      pd_reg <= dsc_pkg::PD_NORMAL;
      ref_dis_reg <= 1'b0;
      gain_reg <= 1'b0;
      daisy_chain_enable_reg <= 1'b0;
    end
    else
    begin
      soft_rst_reg <= 1'b0;
      if (wr_ctrl)
      begin
        pd_reg <= shift_reg[dsc_pkg::CTL_PD_HI:dsc_pkg::CTL_PD_LO];
        ref_dis_reg <= shift_reg[dsc_pkg::CTL_REFDIS];
        gain_reg <= shift_reg[dsc_pkg::CTL_GAIN];
        daisy_chain_enable_reg <= shift_reg[dsc_pkg::CTL_DAISY_CHAIN_ENABLE];
      end
      else if (sync_rise && rb_active_reg)
      begin
        daisy_chain_enable_reg <= 1'b0;
      end
    end
  end

  // Data-out: readback word or chained shift data, else released
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rb_pending_reg <= 1'b0;
      rb_active_reg <= 1'b0;
      rb_shift_reg <= 24'h000000;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else if (hw_act)
    begin
      rb_pending_reg <= 1'b0;
      rb_active_reg <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else if (sync_fall && cfg_reg[dsc_pkg::CFG_FRAME_EN])
    begin
      rb_active_reg <= rb_pending_reg;
      rb_pending_reg <= 1'b0;
      rb_shift_reg <= {4'h0, input_reg, 4'h0};
      sdo_out <= rb_pending_reg ? 1'b0 : shift_reg[23];
      sdo_oe <= rb_pending_reg || daisy_chain_enable_reg;
    end
    else if (sync_rise)
    begin
      rb_active_reg <= 1'b0;
      rb_pending_reg <= frame_done && cmd == dsc_pkg::CMD_READBACK;
      sdo_oe <= 1'b0;
    end
    else if (sclk_fall && in_frame_reg)
    begin
      rb_shift_reg <= {rb_shift_reg[22:0], 1'b0};
      sdo_out <= rb_active_reg ? rb_shift_reg[22] : shift_reg[22];
    end
  end

  // Output path power state
  dsc_pkg::dsc_out_state_t state_reg;
  logic [dsc_pkg::WAKE_CNT_BITS-1:0] wake_cnt_reg;
  logic pd_active;
  assign pd_active = pd_reg != dsc_pkg::PD_NORMAL;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= dsc_pkg::DSC_ST_ACTIVE;
      wake_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        dsc_pkg::DSC_ST_ACTIVE:
        begin
          if (pd_active)
          begin
            state_reg <= dsc_pkg::DSC_ST_DOWN;
          end
        end
        dsc_pkg::DSC_ST_DOWN:
        begin
          if (!pd_active)
          begin
            state_reg <= dsc_pkg::DSC_ST_WAKE;
            wake_cnt_reg <= ref_dis_reg
              ? dsc_pkg::WAKE_CNT_BITS'(WAKE_OFF_CYC - 1)
              : dsc_pkg::WAKE_CNT_BITS'(WAKE_ON_CYC - 1);
          end
        end
        dsc_pkg::DSC_ST_WAKE:
        begin
          if (pd_active)
          begin
            state_reg <= dsc_pkg::DSC_ST_DOWN;
          end
          else if (wake_cnt_reg == '0)
          begin
            state_reg <= dsc_pkg::DSC_ST_ACTIVE;
          end
          else
          begin
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
          end
        end
        default:
        begin
          state_reg <= dsc_pkg::DSC_ST_ACTIVE;
        end
      endcase
    end
  end

  // Reference start is held off while the reset pin stays low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_init_reg <= 1'b0;
    end
    else if (!hw_act)
    begin
      ref_init_reg <= 1'b1;
    end
  end

  // Analog controls, all registered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      amp_enable <= 1'b0;
      load_1k_en <= 1'b0;
      load_100k_en <= 1'b0;
      out_hiz <= 1'b0;
      sdo_pull_en <= 1'b0;
      ref_enable <= 1'b0;
      bias_enable <= 1'b0;
      output_valid <= 1'b0;
      gain_double <= 1'b0;
      dac_code <= dsc_pkg::CODE_RESET;
    end
    else
    begin
      amp_enable <= state_reg != dsc_pkg::DSC_ST_DOWN && !pd_active;
      load_1k_en <= pd_reg == dsc_pkg::PD_1K;
      load_100k_en <= pd_reg == dsc_pkg::PD_100K;
      out_hiz <= pd_reg == dsc_pkg::PD_HIZ;
      sdo_pull_en <= !pd_active;
      ref_enable <= ref_init_reg && !ref_dis_reg;
      bias_enable <= ref_init_reg;
      output_valid <= state_reg == dsc_pkg::DSC_ST_ACTIVE && !pd_active;
      gain_double <= gain_reg;
      dac_code <= dac_reg;
    end
  end

  // APB slave: no wait states, answer prepared in the setup cycle
  logic apb_setup;
  assign apb_setup = psel && !penable && !pready;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (apb_setup)
    begin
      pready <= 1'b1;
      pslverr <= paddr != dsc_pkg::APB_CFG && paddr != dsc_pkg::APB_CODES
        && paddr != dsc_pkg::APB_STATE;
      case (paddr)
        dsc_pkg::APB_CFG: prdata <= {30'h00000000, cfg_reg};
        dsc_pkg::APB_CODES: prdata <= {dac_reg, input_reg};
        dsc_pkg::APB_STATE: prdata <= {19'h00000, ref_init_reg, hw_act,
          state_reg == dsc_pkg::DSC_ST_WAKE, rb_pending_reg, output_valid,
          2'h0, soft_rst_reg, pd_reg, ref_dis_reg, gain_reg, daisy_chain_enable_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_reg <= dsc_pkg::CFG_RESET;
    end
    else if (psel && penable && pready && pwrite && paddr == dsc_pkg::APB_CFG)
    begin
      cfg_reg <= pwdata[1:0];
    end
  end

  property p_wr_input;
    @(posedge clk) disable iff (!rst_b)
    frame_done && cmd == dsc_pkg::CMD_WR_INPUT |=> input_reg == $past(code_in);
  endproperty
  a_wr_input: assert property (p_wr_input) else $error("input write lost");

  property p_amp_off;
    @(posedge clk) disable iff (!rst_b)
    state_reg == dsc_pkg::DSC_ST_DOWN |=> !amp_enable;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("amp on in power-down");

  property p_pull_off;
    @(posedge clk) disable iff (!rst_b)
    pd_active |=> !sdo_pull_en;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull kept in power-down");

  property p_soft_rst;
    @(posedge clk) disable iff (!rst_b)
    do_soft_rst |=> dac_reg == 16'h0000 && input_reg == 16'h0000 && soft_rst_reg
      ##1 !soft_rst_reg;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset wrong");

  property p_load;
    @(posedge clk) disable iff (!rst_b)
    hw_load && !hw_act && !frame_done
      |=> dac_reg == $past(input_reg) ##1 dac_code == $past(dac_reg);
  endproperty
  a_load: assert property (p_load) else $error("load strobe not applied");

  property p_load_ignored;
    @(posedge clk) disable iff (!rst_b)
    load_fall && in_frame_reg && !sync_rise && !hw_act |=> $stable(dac_reg);
  endproperty
  a_load_ignored: assert property (p_load_ignored)
    else $error("load taken mid-frame");

  property p_hw_reset;
    @(posedge clk) disable iff (!rst_b)
    hw_act |=> !in_frame_reg && dac_reg == 16'h0000 && !sdo_oe;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset pin not obeyed");

  property p_sdo_release;
    @(posedge clk) disable iff (!rst_b)
    !in_frame_reg && !sync_fall |=> !sdo_oe;
  endproperty
  a_sdo_release: assert property (p_sdo_release)
    else $error("data-out driven idle");

  property p_daisy_chain_enable_clear;
    @(posedge clk) disable iff (!rst_b)
    sync_rise && rb_active_reg && !wr_ctrl |=> !daisy_chain_enable_reg;
  endproperty
  a_daisy_chain_enable_clear: assert property (p_daisy_chain_enable_clear) else $error("chain flag kept");

  property p_wake_on;
    @(posedge clk) disable iff (!rst_b)
    state_reg == dsc_pkg::DSC_ST_DOWN && !pd_active && !ref_dis_reg
      |=> !output_valid [*8] ##[1:WAKE_ON_BOUND] output_valid || pd_active;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake delay wrong");

  property p_ref_hold;
    @(posedge clk) disable iff (!rst_b)
    !ref_init_reg |-> !ref_enable && !bias_enable;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference started early");
endmodule

/* File: verification/dsc_host_model.sv */
// Host model: drives frames, the load strobe and the reset pin.
// Assumes clk at 125 MHz; pins change just after a clk rise.
`timescale 1ns/1ps
module dsc_host_model (
  input wire logic clk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic sclk,
  output logic frame_sync_n,
  output logic sdi,
  output logic load_strobe_n,
  output logic hw_reset_n
);
  logic sdo_last;
  // Released line shows the inverse, never a stale value
  wire logic sdo_line = sdo_oe ? sdo_out : ~sdo_last;
  initial
  begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    sdi = 1'b0;
    load_strobe_n = 1'b1;
    hw_reset_n = 1'b0;
    sdo_last = 1'b0;
  end
  always @(posedge clk)
    if (sdo_oe)
      sdo_last <= sdo_out;
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Sclk period 10 clk, so 80 ns; idle high outside frames
  task send(input logic [23:0] w, input bit mid, output logic [23:0] rd);
    int i;
    wt(1);
    frame_sync_n <= 1'b0;
    for (i = 23; i >= 0; i--)
    begin
      sdi <= w[i];
      wt(5);
      sclk <= 1'b0;
      if (mid && i == 12)
        load_strobe_n <= 1'b0;
      wt(4);
      @(negedge clk);
      rd[i] = sdo_line;
      @(posedge clk);
      sclk <= 1'b1;
      load_strobe_n <= 1'b1;
    end
    wt(5);
    frame_sync_n <= 1'b1;
    sdi <= ~sdi;
    wt(12);
  endtask
  task strobe;
    wt(1);
    load_strobe_n <= 1'b0;
    wt(8);
    load_strobe_n <= 1'b1;
    wt(8);
  endtask
  // Ten cycles low is 80 ns, above the minimum pulse
  task set_rst(input logic v);
    wt(1);
    hw_reset_n <= v;
    wt(10);
  endtask
endmodule

/* File: verification/dac_serial_control_reset_readback_tb.sv */
// Self-checking bench for dsc_core with APB reads and a host model.
// Assumes the default CFG enables frames and the load strobe.
`timescale 1ns/1ps
module dac_serial_control_reset_readback_tb;
  localparam int WOFF = 200;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sclk, fs_n, sdi, ld_n, hwr_n, sdo_out, sdo_oe, sdo_pull_en;
  logic [15:0] dac_code, code, ed, ei;
  logic amp_enable, load_1k_en, load_100k_en, out_hiz;
  logic gain_double, ref_enable, bias_enable, output_valid;
  logic [23:0] rb;
  int n_fail, n_compared, seed, cyc, k, cnt;
  dsc_host_model i_host (.clk(clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sclk(sclk),
    .frame_sync_n(fs_n), .sdi(sdi), .load_strobe_n(ld_n), .hw_reset_n(hwr_n));
  dsc_core #(.WAKE_OFF_CYC(WOFF)) i_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .frame_sync_n(fs_n), .sdi(sdi), .load_strobe_n(ld_n), .hw_reset_n(hwr_n),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdo_pull_en(sdo_pull_en), .dac_code(dac_code),
    .amp_enable(amp_enable), .load_1k_en(load_1k_en), .load_100k_en(load_100k_en),
    .out_hiz(out_hiz), .gain_double(gain_double), .ref_enable(ref_enable),
    .bias_enable(bias_enable), .output_valid(output_valid), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task complete_run;
    $display("fails %0d compared %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task ck(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Read at the sampling edge, before the slave's own update lands
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task codes;
    apb(1'b0, dsc_pkg::APB_CODES, 32'h0);
    chk(rd, {ed, ei}, "register codes");
    chk({16'h0, dac_code}, {16'h0, ed}, "dac output code");
  endtask
  task fr(input logic [23:0] w);
    i_host.send(w, 1'b0, rb);
  endtask
  function automatic logic [23:0] wr(input logic [3:0] c, input logic [15:0] v);
    return {c, v, 4'h0};
  endfunction
  function automatic logic [23:0] ctl(input logic sr, input logic [1:0] pd,
    input logic rf, input logic gn, input logic dc);
    return {dsc_pkg::CMD_WR_CTRL, sr, pd, rf, gn, dc, 14'h0000};
  endfunction
  initial
  begin
    seed = 32'hC0A4;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, n_compared, cyc} = '0;
    ed = 16'h0000;
    ei = 16'h0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    i_host.wt(20);
    ck(bias_enable, 1'b0, "bias before pin release");
    apb(1'b0, dsc_pkg::APB_CFG, 32'h0);
    chk(rd, {30'h0, dsc_pkg::CFG_RESET}, "cfg reset value");
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    ck(e, 1'b1, "unmapped error");
    i_host.set_rst(1'b1);
    ck(bias_enable, 1'b1, "bias after pin release");
    codes();
    for (k = 0; k < 3; k++)
    begin
      code = 16'($random(seed));
      fr(wr(dsc_pkg::CMD_WR_INPUT, code));
      ei = code;
      codes();
      i_host.send(wr(dsc_pkg::CMD_NOP, ~code), 1'b1, rb);
      codes();
      i_host.strobe();
      ed = ei;
      codes();
      code = 16'($random(seed));
      fr(wr(dsc_pkg::CMD_WR_BOTH, code));
      {ed, ei} = {code, code};
      codes();
      fr(wr(dsc_pkg::CMD_WR_INPUT, ~code));
      ei = ~code;
      fr(wr(dsc_pkg::CMD_UPDATE, 16'h0000));
      ed = ei;
      codes();
    end
    for (k = 0; k < 4; k++)
    begin
      fr(ctl(1'b0, k[1:0], 1'b0, 1'b0, 1'b0));
      ck(amp_enable, k == 0, "amplifier");
      chk({load_1k_en, load_100k_en, out_hiz}, {k == 1, k == 2, k == 3}, "load");
      ck(sdo_pull_en, k == 0, "data-out pull");
      chk({bias_enable, ref_enable}, 2'b11, "bias and reference");
      code = 16'($random(seed));
      fr(wr(dsc_pkg::CMD_WR_BOTH, code));
      {ed, ei} = {code, code};
      codes();
    end
    fr(ctl(1'b0, dsc_pkg::PD_HIZ, 1'b1, 1'b0, 1'b0));
    chk({bias_enable, ref_enable}, 2'b10, "reference off");
    for (k = 0; k < 2; k++)
    begin
      fr(ctl(1'b0, dsc_pkg::PD_1K, k[0], 1'b0, 1'b0));
      ck(output_valid, 1'b0, "valid in power-down");
      fr(ctl(1'b0, dsc_pkg::PD_NORMAL, k[0], 1'b0, 1'b0));
      cnt = 0;
      while (output_valid !== 1'b1 && cnt < 2000)
      begin
        @(negedge clk);
        cnt++;
      end
      cnt = cnt - (k == 1 ? WOFF : dsc_pkg::WAKE_REF_ON_CYC);
      ck(cnt >= -30 && cnt <= 5, 1'b1, "wake delay");
    end
    fr(24'h180000);
    ei = 16'h8000;
    fr(ctl(1'b0, dsc_pkg::PD_NORMAL, 1'b0, 1'b0, 1'b1));
    i_host.send(24'h500000, 1'b0, rb);
    i_host.send(24'h000000, 1'b0, rb);
    chk({16'h0, rb[19:4]}, 32'h8000, "readback code");
    ck(sdo_oe, 1'b0, "data-out released");
    apb(1'b0, dsc_pkg::APB_STATE, 32'h0);
    ck(rd[0], 1'b0, "chain flag after readback");
    fr(ctl(1'b0, dsc_pkg::PD_NORMAL, 1'b0, 1'b1, 1'b1));
    ck(gain_double, 1'b1, "gain set");
    fr(ctl(1'b1, dsc_pkg::PD_NORMAL, 1'b0, 1'b1, 1'b1));
    {ed, ei} = '0;
    codes();
    ck(gain_double, 1'b0, "gain default");
    apb(1'b0, dsc_pkg::APB_STATE, 32'h0);
    chk({30'h0, rd[5], rd[0]}, 32'h0, "soft reset bit and flag");
    code = 16'($random(seed)) | 16'h0001;
    fr(wr(dsc_pkg::CMD_WR_BOTH, code));
    i_host.set_rst(1'b0);
    codes();
    fr(wr(dsc_pkg::CMD_WR_BOTH, code));
    codes();
    i_host.set_rst(1'b1);
    i_host.strobe();
    codes();
    // Strobe gated off by software must leave the DAC register alone
    fr(wr(dsc_pkg::CMD_WR_INPUT, code));
    ei = code;
    apb(1'b1, dsc_pkg::APB_CFG, 32'h0000_0002);
    apb(1'b0, dsc_pkg::APB_CFG, 32'h0);
    chk(rd, 32'h0000_0002, "cfg write");
    i_host.strobe();
    codes();
    complete_run();
  end
endmodule
